/* ifl_host_model.sv */
// host-side model that issues register commands to the limit block
`timescale 1ns/1ps
module ifl_host_model (
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic [15:0] rdata_in,
    output logic             wr_out,
    output logic             rd_out,
    output logic             word_out,
    output logic [7:0]       code_out,
    output logic [15:0]      wdata_out
);
    ////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        wr_out = 1'b0;
        rd_out = 1'b0;
        word_out = 1'b0;
        code_out = 8'h00;
        wdata_out = 16'h0000;
    end
    ////////////////////////////////////////////////////////////////////////
    // strobe for one edge only, since a held strobe would be taken twice;
    // qualifiers stay until ack, then code and data are scrambled so stale data shows
    task automatic xfer(input logic w, input logic wd, input logic [7:0] c,
                        input logic [15:0] d, output logic [15:0] r);
        int n;
        n = 0;
        r = 'x;
        @(posedge clk_in);
        #1;
        wr_out = w;
        rd_out = !w;
        word_out = wd;
        code_out = c;
        wdata_out = d;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        rd_out = 1'b0;
        while (ack_in !== 1'b1 && n < 8) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        if (ack_in === 1'b1) r = rdata_in;
        code_out = ~c;
        wdata_out = ~d;
    endtask : xfer
endmodule : ifl_host_model

/* ifl_pkg.sv */
// package: command codes, field layouts, defaults and status bits
package ifl_pkg;
    // command codes
    localparam logic [7:0] CMD_UV_LIMIT     = 8'h59;
    localparam logic [7:0] CMD_UV_RESPONSE  = 8'h5A;
    localparam logic [7:0] CMD_OC_FAULT_LIM = 8'h5B;
    localparam logic [7:0] CMD_OC_RESPONSE  = 8'h5C;
    localparam logic [7:0] CMD_OC_WARN_LIM  = 8'h5D;
    localparam logic [7:0] CMD_STATUS_BYTE  = 8'h78;
    localparam logic [7:0] CMD_STATUS_WORD  = 8'h79;
    localparam logic [7:0] CMD_STATUS_INPUT = 8'h7C;
    localparam logic [7:0] CMD_ALERT_MASK   = 8'h1B;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    // linear format field positions
    localparam int EXP_HI = 15;
    localparam int EXP_LO = 11;
    localparam int MAN_HI = 10;
    // fixed values
    localparam logic [7:0]  UV_RESP_CODE   = 8'hC0;
    localparam logic [7:0]  OC_RESP_CODE   = 8'hC0;
    localparam logic [4:0]  OC_EXP_FIXED   = 5'h1F;
    localparam logic [10:0] OC_MAN_MAX     = 11'h07F;
    localparam logic [15:0] OC_DEFAULT     = 16'hF87F;
    localparam logic [15:0] OC_KEEP_LO     = 16'hF810;
    localparam logic [15:0] OC_KEEP_HI     = 16'hF870;
    localparam logic [15:0] OC_KEEP_MAX    = 16'hF87F;
    localparam logic [3:0]  OC_KEEP_NIB0   = 4'h0;
    localparam logic [7:0]  ALERT_MASK_RST = 8'h00;
    // status bit positions
    localparam int SB_OTHER     = 0;
    localparam int SW_INPUT     = 13;
    localparam int SI_OC_WARN   = 1;
    localparam int SI_OC_FAULT  = 2;
    localparam int SI_UV_FAULT  = 4;
    // measurement scale: volts and amps in 1/1024 units
    localparam int MEAS_FRAC    = 10;
endpackage : ifl_pkg

/* ifl_regs.sv */
// input fault limit registers, comparators and status for the controller
`timescale 1ns/1ps
// Notes on behaviour
// (RULE1) uv limit: writable 5-bit exponent and 11-bit mantissa, nvm loaded
// (RULE2) host writes uv limit only with the listed codes
// (RULE3) response registers are byte-read only; writes ignored
// (RULE4) these commands act on both channels regardless of page
// (RULE5) uv fault sets other, input and uv status bits
// (RULE6) input events raise alert unless masked
// (RULE7) uv response reads C0h; shut down, restart when uv clears
// (RULE8) oc limits: exponent fixed 11111b, mantissa writable 0..127
// (RULE9) new oc limits apply at once during operation
// (RULE10) restore keeps F810h..F870h steps or F87Fh, else 63.5 A
// (RULE11) warn when input current exceeds warn limit
// (RULE12) oc warning sets other, input and oc warn status bits
// (RULE13) fault when input current exceeds oc fault limit
// (RULE14) oc fault latches off, sets status, alert and fault output
// (RULE15) host uses word transactions for the limit registers
// (RULE16) uv fault masked until vin first passes turn-on and enabled
// (RULE17) limits decoded as mantissa times two to the exponent
// (RULE18) status bits stay set until host clears them
module ifl_regs
    import ifl_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        nvm_load_in,
    input  wire logic [15:0] nvm_uv_limit_in,
    input  wire logic [15:0] nvm_oc_fault_in,
    input  wire logic [15:0] nvm_oc_warn_in,
    input  wire logic        cmd_wr_in,
    input  wire logic        cmd_rd_in,
    input  wire logic        cmd_word_in,
    input  wire logic [7:0]  cmd_code_in,
    input  wire logic [15:0] cmd_wdata_in,
    input  wire logic [7:0]  page_in,
    output logic      [15:0] cmd_rdata_out,
    output logic             cmd_ack_out,
    input  wire logic [31:0] vin_meas_in,
    input  wire logic [31:0] iin_meas_in,
    input  wire logic        vin_above_on_in,
    input  wire logic        unit_enable_in,
    output logic             conv_run_out,
    output logic             host_alert_line_out,
    output logic             regulator_fault_output_out
);

    typedef struct packed {
        logic [15:0] uv_lim;
        logic [15:0] ocf_lim;
        logic [15:0] ocw_lim;
        logic [7:0]  mask;
        logic [7:0]  st_input;
        logic        st_other;
        logic        st_inword;
        logic        uv_armed;
        logic        oc_latched;
        logic        alert;
        logic        vrf;
        logic [15:0] rdata;
        logic        ack;
        logic        run;
    } ifl_state_t;

    ifl_state_t s_q;
    ifl_state_t s_d;
    logic       uv_now;
    logic       ocw_now;
    logic       ocf_now;
    logic       set_any;

    ////////////////////////////////////////////////////////////////////////
    // decode a linear word into the measurement scale
    function automatic logic [31:0] lin_val(input logic [15:0] w);
        logic signed [4:0]  e;
        logic        [47:0] m;
        e = signed'(w[EXP_HI:EXP_LO]);
        m = {37'h0, w[MAN_HI:0]} << MEAS_FRAC;
        if (e < 0) begin
            m = m >> (-e);
        end else begin
            m = m << e;
        end
        return m[31:0];
    endfunction : lin_val

    // restore filter: only the coarse steps and F87Fh survive nvm
    function automatic logic [15:0] oc_restore(input logic [15:0] w);
        if (w == OC_KEEP_MAX) begin
            return w;
        end else if (w >= OC_KEEP_LO && w <= OC_KEEP_HI
                     && w[3:0] == OC_KEEP_NIB0) begin
            return w;
        end
        return OC_DEFAULT;
    endfunction : oc_restore

    // oc limit writes keep only the mantissa; exponent is fixed
    function automatic logic [15:0] oc_word(input logic [15:0] d);
        return {OC_EXP_FIXED, d[MAN_HI:0]};
    endfunction : oc_word

    // mantissa range check shared by both oc limit writes
    function automatic logic oc_mant_ok(input logic [15:0] d);
        return d[MAN_HI:0] <= OC_MAN_MAX;
    endfunction : oc_mant_ok

    ////////////////////////////////////////////////////////////////////////
    // comparators run on every clock so new limits act at once
    assign uv_now  = s_q.uv_armed
                     && (vin_meas_in < lin_val(s_q.uv_lim));  // RULE17
    assign ocw_now = iin_meas_in > lin_val(s_q.ocw_lim);      // RULE11 RULE9
    assign ocf_now = iin_meas_in > lin_val(s_q.ocf_lim);      // RULE13 RULE9
    assign set_any = uv_now || ocw_now || ocf_now;

    ////////////////////////////////////////////////////////////////////////
    // next state; page_in is deliberately not decoded
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        // uv only arms after turn-on seen and unit enabled
        if (vin_above_on_in && unit_enable_in) begin
            s_d.uv_armed = 1'b1;                              // RULE16
        end
        // host write; clear first so a same-cycle event wins
        if (cmd_wr_in) begin
            s_d.ack = 1'b1;
            if (cmd_code_in == CMD_UV_LIMIT && cmd_word_in) begin
                s_d.uv_lim = cmd_wdata_in;                    // RULE1 RULE4
            end else if (cmd_code_in == CMD_OC_FAULT_LIM && cmd_word_in) begin
                if (oc_mant_ok(cmd_wdata_in)) begin
                    s_d.ocf_lim = oc_word(cmd_wdata_in);      // RULE8
                end
            end else if (cmd_code_in == CMD_OC_WARN_LIM && cmd_word_in) begin
                if (oc_mant_ok(cmd_wdata_in)) begin
                    s_d.ocw_lim = oc_word(cmd_wdata_in);      // RULE8
                end
            end else if (cmd_code_in == CMD_ALERT_MASK) begin
                s_d.mask = cmd_wdata_in[7:0];
            end else if (cmd_code_in == CMD_CLEAR_FAULTS) begin
                s_d.st_input  = 8'h00;                        // RULE18
                s_d.st_other  = 1'b0;
                s_d.st_inword = 1'b0;
                s_d.alert     = 1'b0;
            end
            // response commands fall through: read only
        end
        // host read
        if (cmd_rd_in) begin
            s_d.ack = 1'b1;
            if (cmd_code_in == CMD_UV_LIMIT) begin
                s_d.rdata = s_q.uv_lim;
            end else if (cmd_code_in == CMD_UV_RESPONSE) begin
                s_d.rdata = {8'h00, UV_RESP_CODE};            // RULE3 RULE7
            end else if (cmd_code_in == CMD_OC_FAULT_LIM) begin
                s_d.rdata = s_q.ocf_lim;
            end else if (cmd_code_in == CMD_OC_RESPONSE) begin
                s_d.rdata = {8'h00, OC_RESP_CODE};            // RULE3
            end else if (cmd_code_in == CMD_OC_WARN_LIM) begin
                s_d.rdata = s_q.ocw_lim;
            end else if (cmd_code_in == CMD_STATUS_BYTE) begin
                s_d.rdata           = 16'h0000;
                s_d.rdata[SB_OTHER] = s_q.st_other;
            end else if (cmd_code_in == CMD_STATUS_WORD) begin
                s_d.rdata           = 16'h0000;
                s_d.rdata[SW_INPUT] = s_q.st_inword;
                s_d.rdata[SB_OTHER] = s_q.st_other;
            end else if (cmd_code_in == CMD_STATUS_INPUT) begin
                s_d.rdata = {8'h00, s_q.st_input};
            end else if (cmd_code_in == CMD_ALERT_MASK) begin
                s_d.rdata = {8'h00, s_q.mask};
            end else begin
                s_d.rdata = 16'h0000;
            end
        end
        // events set sticky status
        if (uv_now) begin
            s_d.st_input[SI_UV_FAULT] = 1'b1;                 // RULE5
        end
        if (ocw_now) begin
            s_d.st_input[SI_OC_WARN] = 1'b1;                  // RULE12
        end
        if (ocf_now) begin
            s_d.st_input[SI_OC_FAULT] = 1'b1;                 // RULE14
            s_d.oc_latched = 1'b1;
            s_d.vrf = 1'b1;
        end
        if (set_any) begin
            s_d.st_other  = 1'b1;                             // RULE5 RULE12
            s_d.st_inword = 1'b1;
        end
        // alert unless the event's mask bit is set
        if ((uv_now && !s_q.mask[SI_UV_FAULT])
            || (ocw_now && !s_q.mask[SI_OC_WARN])
            || (ocf_now && !s_q.mask[SI_OC_FAULT])) begin
            s_d.alert = 1'b1;                                 // RULE6 RULE14
        end
        // uv shuts down only while present; oc latches off
        s_d.run = unit_enable_in && !uv_now && !s_d.oc_latched; // RULE7
        // nvm restore overrides a same-cycle write; status is untouched
        if (nvm_load_in) begin
            s_d.uv_lim  = nvm_uv_limit_in;                    // RULE1
            s_d.ocf_lim = oc_restore(nvm_oc_fault_in);        // RULE10
            s_d.ocw_lim = oc_restore(nvm_oc_warn_in);         // RULE10
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; oc latch cleared only by reset
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s_q <= '0;
            s_q.ocf_lim <= OC_DEFAULT;
            s_q.ocw_lim <= OC_DEFAULT;
            s_q.mask    <= ALERT_MASK_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign cmd_rdata_out              = s_q.rdata;
    assign cmd_ack_out                = s_q.ack;
    assign conv_run_out               = s_q.run;
    assign host_alert_line_out        = s_q.alert;
    assign regulator_fault_output_out = s_q.vrf;

    ////////////////////////////////////////////////////////////////////////
    // checks; all on the core clock, off while reset is low
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);

    // oc fault: all three status bits one edge later
    a_ocf_status: assert property (                           // RULE14
        ocf_now |=> s_q.st_input[SI_OC_FAULT] && s_q.st_other
        && s_q.st_inword)
        else $error("oc fault status not set");

    // oc fault: converter stays off and fault output stays up
    a_ocf_latch: assert property (                            // RULE14
        ocf_now |=> (!conv_run_out && regulator_fault_output_out) [*3])
        else $error("oc fault did not latch off");

    // oc warning sets its input warn and other status bits
    a_ocw_status: assert property (                           // RULE12
        ocw_now |=> s_q.st_input[SI_OC_WARN] && s_q.st_other)
        else $error("oc warn status missing");

    // uv fault sets its status bits
    a_uv_status: assert property (                            // RULE5
        uv_now |=> s_q.st_input[SI_UV_FAULT] && s_q.st_other
        && s_q.st_inword)
        else $error("uv status missing");

    // no uv status may appear before the comparison is armed
    a_uv_masked: assert property (                            // RULE16
        !s_q.uv_armed |-> !s_q.st_input[SI_UV_FAULT])
        else $error("uv seen before arming");

    // uv fault stops the converter while it lasts
    a_uv_run_off: assert property (                           // RULE7
        uv_now |=> !conv_run_out)
        else $error("converter ran through uv fault");

    // unmasked warning raises the alert line
    a_alert_set: assert property (                            // RULE6
        ocw_now && !s_q.mask[SI_OC_WARN] |=> host_alert_line_out)
        else $error("alert not raised");

    // exponent of both oc limits never leaves its fixed value
    a_oc_exp_fixed: assert property (                         // RULE8
        s_q.ocf_lim[EXP_HI:EXP_LO] == OC_EXP_FIXED
        && s_q.ocw_lim[EXP_HI:EXP_LO] == OC_EXP_FIXED)
        else $error("oc exponent changed");

    // out of range oc mantissa leaves the limit as it was
    a_oc_refuse: assert property (                            // RULE8
        cmd_wr_in && cmd_code_in == CMD_OC_FAULT_LIM && !nvm_load_in
        && !oc_mant_ok(cmd_wdata_in) |=> $stable(s_q.ocf_lim))
        else $error("oc limit took a bad mantissa");

    // valid oc fault limit takes effect at the next edge, no restart
    a_oc_apply: assert property (                             // RULE9
        cmd_wr_in && cmd_word_in && cmd_code_in == CMD_OC_FAULT_LIM
        && !nvm_load_in && oc_mant_ok(cmd_wdata_in)
        |=> ((s_q.ocf_lim ^ $past(cmd_wdata_in)) & 16'h07FF) == 16'h0000)
        else $error("oc limit write not applied");

    // uv response code reads back fixed
    a_resp_read: assert property (                            // RULE7
        cmd_rd_in && cmd_code_in == CMD_UV_RESPONSE
        |=> cmd_rdata_out == 16'h00C0)
        else $error("uv response code wrong");

    // status holds until a clear command
    a_status_sticky: assert property (                        // RULE18
        s_q.st_other && !(cmd_wr_in && cmd_code_in == CMD_CLEAR_FAULTS)
        |=> s_q.st_other)
        else $error("status dropped without clear");

    // clear with no event in the same cycle empties status and alert
    a_clear_status: assert property (                         // RULE18
        cmd_wr_in && cmd_code_in == CMD_CLEAR_FAULTS && !set_any
        |=> !s_q.st_other && !host_alert_line_out)
        else $error("clear faults did not clear");

    // odd stored oc word restores as the top limit
    a_restore_filter: assert property (                       // RULE10
        nvm_load_in && !cmd_wr_in && nvm_oc_fault_in == 16'hF835
        |=> s_q.ocf_lim == OC_DEFAULT)
        else $error("restore filter wrong");

    // main scenarios the bench should reach
    c_uv_fault:  cover property (uv_now);
    c_oc_fault:  cover property (ocf_now ##1 regulator_fault_output_out);
    c_oc_warn:   cover property (ocw_now && !ocf_now);
    c_uv_return: cover property (uv_now ##1 !uv_now ##1 conv_run_out);
    c_restore:   cover property (nvm_load_in ##1 s_q.ocf_lim == OC_DEFAULT);

endmodule : ifl_regs

/* tb_top.sv */
// bench: register access, limit events and restore for ifl_regs
`timescale 1ns/1ps
module tb_top;
    logic        core_clk_in  = 1'b0;
    logic        rst_b_in     = 1'b0;
    logic        nvm_load     = 1'b0;
    logic [15:0] nvm_w        = 16'h0000;
    logic [15:0] nvm_uv       = 16'h0000;
    logic [7:0]  page         = 8'h00;
    logic [31:0] vin          = 32'd12288;
    logic [31:0] iin          = 32'd0;
    logic        von          = 1'b0;
    logic        ena          = 1'b0;
    logic        wr, rd, word, ack, run, alert, vrf;
    logic [7:0]  code;
    logic [15:0] wdata, rdata, r;
    int          n_mismatch   = 0;
    int          total_checks = 0;
    int          cyc          = 0;
    // legal undervoltage codes; oc words as stored and as restored
    logic [15:0] uvc [8] = '{16'hF011, 16'hF80B, 16'hF80D, 16'hF80F,
                             16'hF811, 16'hF813, 16'hF815, 16'hF817};
    logic [15:0] ocs [6] = '{16'hF810, 16'hF870, 16'hF87F, 16'hF835,
                             16'hF805, 16'hF860};
    logic [15:0] oce [6] = '{16'hF810, 16'hF870, 16'hF87F, 16'hF87F,
                             16'hF87F, 16'hF860};
    always #5 core_clk_in = ~core_clk_in;
    ifl_regs u_ifl_regs (.core_clk_in(core_clk_in), .rst_b_in(rst_b_in),
        .nvm_load_in(nvm_load), .nvm_uv_limit_in(nvm_uv),
        .nvm_oc_fault_in(nvm_w), .nvm_oc_warn_in(nvm_w), .cmd_wr_in(wr),
        .cmd_rd_in(rd), .cmd_word_in(word), .cmd_code_in(code),
        .cmd_wdata_in(wdata), .page_in(page), .cmd_rdata_out(rdata),
        .cmd_ack_out(ack), .vin_meas_in(vin), .iin_meas_in(iin),
        .vin_above_on_in(von), .unit_enable_in(ena), .conv_run_out(run),
        .host_alert_line_out(alert), .regulator_fault_output_out(vrf));
    ifl_host_model u_ifl_host_model (.clk_in(core_clk_in), .ack_in(ack),
        .rdata_in(rdata), .wr_out(wr), .rd_out(rd), .word_out(word),
        .code_out(code), .wdata_out(wdata));
    ////////////////////////////////////////////////////////////////////////
    // compare helpers
    task automatic chk(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rdc(input logic [7:0] c, input logic [15:0] m,
                       input logic [15:0] e);
        u_ifl_host_model.xfer(1'b0, 1'b1, c, 16'h0000, r);
        chk($sformatf("read %h", c), e, r & m);
    endtask : rdc
    task automatic wrc(input logic [7:0] c, input logic [15:0] d,
                       input logic wd);
        u_ifl_host_model.xfer(1'b1, wd, c, d, r);
    endtask : wrc
    // one edge lets registered event outputs land
    task automatic tick(input logic [2:0] e, input string nm);
        @(posedge core_clk_in);
        #1;
        chk(nm, {13'h0000, e}, {13'h0000, run, alert, vrf});
    endtask : tick
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : print_verdict
    // hang guard, far above the roughly 140 cycles the tests need
    always @(posedge core_clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk_in);
        #1;
        rst_b_in = 1'b1;
        rdc(8'h5A, 16'hFFFF, 16'h00C0);
        wrc(8'h5C, 16'h0011, 1'b0);
        rdc(8'h5C, 16'hFFFF, 16'h00C0);
        rdc(8'h5B, 16'hFFFF, 16'hF87F);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            page = i[0] ? 8'hFF : 8'h01;
            wrc(8'h59, uvc[i], 1'b1);
            page = 8'h00;
            rdc(8'h59, 16'hFFFF, uvc[i]);
        end
        wrc(8'h59, 16'hF80B, 1'b0);
        rdc(8'h59, 16'hFFFF, 16'hF817);
        wrc(8'h5B, 16'h0020, 1'b1);
        wrc(8'h5B, 16'h0080, 1'b1);
        rdc(8'h5B, 16'hFFFF, 16'hF820);
        wrc(8'h5D, 16'h0010, 1'b1);
        rdc(8'h5D, 16'hFFFF, 16'hF810);
        $display("test limits done");
        von = 1'b1;
        ena = 1'b1;
        iin = 32'd8192;
        tick(3'b100, "warn at limit");
        iin = 32'd8193;
        tick(3'b110, "warn alert");
        iin = 32'd0;
        rdc(8'h7C, 16'h0016, 16'h0002);
        rdc(8'h78, 16'h0001, 16'h0001);
        rdc(8'h79, 16'h2000, 16'h2000);
        wrc(8'h03, 16'h0000, 1'b0);
        wrc(8'h1B, 16'h0002, 1'b0);
        iin = 32'd8193;
        tick(3'b100, "masked warn");
        rdc(8'h7C, 16'h0016, 16'h0002);
        wrc(8'h5B, 16'h007F, 1'b1);
        iin = 32'd16385;
        tick(3'b100, "below fault");
        wrc(8'h5B, 16'h0020, 1'b1);
        tick(3'b011, "oc fault");
        rdc(8'h7C, 16'h0004, 16'h0004);
        iin = 32'd0;
        wrc(8'h03, 16'h0000, 1'b0);
        tick(3'b001, "oc latched");
        $display("test events done");
        von = 1'b0;
        ena = 1'b0;
        rst_b_in = 1'b0;
        @(posedge core_clk_in);
        #1;
        rst_b_in = 1'b1;
        wrc(8'h59, 16'hF811, 1'b1);
        vin = 32'd8192;
        tick(3'b000, "uv unarmed");
        von = 1'b1;
        ena = 1'b1;
        vin = 32'd10240;
        tick(3'b100, "uv run");
        vin = 32'd8192;
        tick(3'b010, "uv trip");
        rdc(8'h7C, 16'h0010, 16'h0010);
        rdc(8'h79, 16'h2001, 16'h2001);
        vin = 32'd10240;
        tick(3'b110, "uv restart");
        $display("test undervoltage done");
        for (int i = 0; i < 6; i++) begin
            nvm_w = ocs[i];
            nvm_uv = uvc[i];
            nvm_load = 1'b1;
            @(posedge core_clk_in);
            #1;
            nvm_load = 1'b0;
            rdc(8'h5B, 16'hFFFF, oce[i]);
            rdc(8'h5D, 16'hFFFF, oce[i]);
            rdc(8'h59, 16'hFFFF, uvc[i]);
        end
        $display("test restore done");
        print_verdict();
    end
endmodule : tb_top
